/* File: pkg/cfg_check_pkg.sv */
// shared constants and carrier types for the configuration memory error checker
// assumes a single clock domain; sys_clk stands in for the internal configuration oscillator
// Overview of operation
// - the checker keeps recomputing a crc over every configuration cell word and compares it with the reference crc.
// - checking runs forever and only stops when config_restart_n is driven low or rst is raised.
// - only the configuration cell memory is covered; embedded memories and i/o buffers are never scanned.
// - the crc is the 32-bit ieee 802 polynomial, one 32-bit calculation per pass.
// - a clean pass leaves an all-zero result and a low error output, a non-zero result drives it high.
// - the reference register is loaded with the precomputed crc at the end of configuration and used in every pass.
// - the error output is the or of the 32 compare bits, registered on the same edge as the compare result register.
// - while the rewrite instruction runs, the reference register is a 32-bit scan chain the host may overwrite.
// - scanning the reference register never halts or stalls the checking passes.
// - when enabled, checking starts by itself on entering user mode after configuration completes.
// - the error output stays low until a pass finds corruption and then stays high through the next pass.
// - the error output does not latch; a later clean pass drives it low again.
// - the checker runs from the oscillator through a divider, 80 MHz at most and 312.5 kHz at the least.
// - the divider is two to the power of an exponent from 0 to 8, dividing by 1 up to 256.
package cfg_check_pkg;

  // crc arithmetic
  localparam logic [31:0] CRC_POLY = 32'h04C1_1DB7;
  localparam logic [31:0] CRC_INIT = 32'hFFFF_FFFF;
  localparam logic [31:0] RESULT_RESET = 32'h0000_0000;
  localparam logic [31:0] REFERENCE_RESET = 32'h0000_0000;

  // configuration cell array shape
  localparam int CELL_WORDS = 1024;
  localparam int CELL_ADDR_W = 10;
  localparam int CELL_DATA_W = 32;

  // divider limits
  localparam int DIV_EXP_W = 4;
  localparam logic [DIV_EXP_W-1:0] DIV_EXP_MAX = 4'h8;
  localparam logic [DIV_EXP_W-1:0] DIV_EXP_RESET = 4'h0;
  localparam int DIV_CNT_W = 8;
  localparam int OSC_MAX_KHZ = 80000;
  localparam int DETECT_MIN_HZ = 312500;

  // configuration hand-off at the end of loading
  typedef struct packed {
    logic done;
    logic enable;
    logic [DIV_EXP_W-1:0] div_exp;
    logic [31:0] reference;
  } cfg_load_t;

  // writes into the cell array, during configuration or to model an upset
  typedef struct packed {
    logic we;
    logic [CELL_ADDR_W-1:0] addr;
    logic [CELL_DATA_W-1:0] data;
  } cell_write_t;

  typedef enum logic [1:0] {
    st_idle,
    st_load,
    st_fold,
    st_finish
  } check_state_t;

endpackage : cfg_check_pkg

/* File: rtl/cell_memory.sv */
// configuration cell array: one write port, one registered read port
// assumes writes come from the configuration loader; read data lag the address by one edge
`timescale 1ns/100ps
module cell_memory #(
  parameter int WORDS = cfg_check_pkg::CELL_WORDS,
  parameter int ADDR_W = cfg_check_pkg::CELL_ADDR_W,
  parameter int DATA_W = cfg_check_pkg::CELL_DATA_W
) (
  input wire logic sys_clk,
  input wire logic wr_en,
  input wire logic [ADDR_W-1:0] wr_addr,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic [ADDR_W-1:0] rd_addr,
  output logic [DATA_W-1:0] rd_data
);
  import cfg_check_pkg::*;

  logic [DATA_W-1:0] cells [WORDS];

  // no reset on the array: cell contents only come from configuration
  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      cells[wr_addr] <= wr_data;
    end
  end

  // registered read so the crc fold sees a stable word
  always_ff @(posedge sys_clk) begin
    rd_data <= cells[rd_addr];
  end

endmodule : cell_memory

/* File: rtl/detect_clock_divider.sv */
// power-of-two tick generator for the checker
// assumes the exponent is held stable while run is high
`timescale 1ns/100ps
module detect_clock_divider (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic run,
  input wire logic [cfg_check_pkg::DIV_EXP_W-1:0] div_exp,
  output logic tick
);
  import cfg_check_pkg::*;

  logic [DIV_CNT_W-1:0] count;
  logic [DIV_CNT_W-1:0] terminal;
  logic [DIV_EXP_W-1:0] exp_clamped;

  // exponents above the top are clamped so the rate never falls below the slowest legal one
  always_comb begin
    exp_clamped = (div_exp > DIV_EXP_MAX) ? DIV_EXP_MAX : div_exp;
    terminal = DIV_CNT_W'((9'h001 << exp_clamped) - 9'h001);
  end

  // tick once every 2**exp edges while running
  always_ff @(posedge sys_clk) begin
    if (rst || !run) begin
      count <= '0;
    end else if (count >= terminal) begin
      count <= '0;
    end else begin
      count <= count + 1'b1;
    end
  end

  assign tick = run && (count >= terminal);

endmodule : detect_clock_divider

/* File: rtl/config_memory_error_check.sv */
// background soft-error checker over the configuration cell array
// assumes the loader fills the cells, then raises cfg_load.done with the reference, enable and divider exponent
`timescale 1ns/100ps
module config_memory_error_check #(
  parameter int WORDS = cfg_check_pkg::CELL_WORDS,
  parameter int ADDR_W = cfg_check_pkg::CELL_ADDR_W
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic config_restart_n,
  input wire cfg_check_pkg::cfg_load_t cfg_load,
  input wire cfg_check_pkg::cell_write_t cell_wr,
  input wire logic rewrite_reference_instr,
  input wire logic jtag_shift,
  input wire logic jtag_tdi,
  output logic jtag_tdo,
  output logic crc_error,
  output logic checking,
  output logic pass_done,
  output logic [31:0] crc_compare_result,
  output logic [31:0] reference_crc_value
);
  import cfg_check_pkg::*;

  check_state_t state;
  logic restart;
  logic done_q;
  logic user_entry;
  logic feature_on;
  logic [DIV_EXP_W-1:0] div_exp;
  logic tick;
  logic [ADDR_W-1:0] scan_addr;
  logic [CELL_DATA_W-1:0] cell_word;
  logic [31:0] crc;
  logic [31:0] next_result;
  logic last_word;

  // one 32-bit word folded msb-first into the running crc
  function automatic logic [31:0] crc_fold(input logic [31:0] c_in, input logic [31:0] d);
    logic [31:0] c;
    logic fb;
    c = c_in;
    fb = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      fb = c[31] ^ d[i];
      c = {c[30:0], 1'b0} ^ (fb ? CRC_POLY : 32'h0000_0000);
    end
    return c;
  endfunction : crc_fold

  // restarting configuration is the only thing besides rst that stops checking
  assign restart = rst || !config_restart_n;
  assign user_entry = cfg_load.done && !done_q;
  assign last_word = (scan_addr == ADDR_W'(WORDS - 1));
  assign next_result = crc ^ reference_crc_value;

  // edge detect on the end of configuration
  always_ff @(posedge sys_clk) begin
    if (restart) begin
      done_q <= 1'b0;
    end else begin
      done_q <= cfg_load.done;
    end
  end

  // enable and divider are captured once on entry to user mode and then frozen
  always_ff @(posedge sys_clk) begin
    if (restart) begin
      feature_on <= 1'b0;
      div_exp <= DIV_EXP_RESET;
    end else if (user_entry) begin
      feature_on <= cfg_load.enable;
      div_exp <= cfg_load.div_exp;
    end
  end

  // reference register: loaded at configuration end, a scan chain under the rewrite instruction
  // the scan does not touch the pass state, so checking carries on while the host shifts
  always_ff @(posedge sys_clk) begin
    if (restart) begin
      reference_crc_value <= REFERENCE_RESET;
    end else if (user_entry) begin
      reference_crc_value <= cfg_load.reference;
    end else if (rewrite_reference_instr && jtag_shift) begin
      reference_crc_value <= {jtag_tdi, reference_crc_value[31:1]};
    end
  end

  // lsb leaves first, so the host reads the old value while writing the new one
  assign jtag_tdo = reference_crc_value[0];

  detect_clock_divider u_divider (
    .sys_clk(sys_clk),
    .rst(restart),
    .run(checking),
    .div_exp(div_exp),
    .tick(tick)
  );

  // only the configuration cells are wired to the scan; block memories have their own parity
  cell_memory #(
    .WORDS(WORDS),
    .ADDR_W(ADDR_W),
    .DATA_W(CELL_DATA_W)
  ) u_cells (
    .sys_clk(sys_clk),
    .wr_en(cell_wr.we),
    .wr_addr(cell_wr.addr[ADDR_W-1:0]), // the carrier is sized for the largest array
    .wr_data(cell_wr.data),
    .rd_addr(scan_addr),
    .rd_data(cell_word)
  );

  // pass sequencer: two ticks per word, load then fold, and one tick to compare
  always_ff @(posedge sys_clk) begin
    if (restart) begin
      state <= st_idle;
    end else begin
      unique case (state)
        st_idle: begin
          if (user_entry && cfg_load.enable) begin
            state <= st_load;
          end
        end
        st_load: begin
          if (tick) begin
            state <= st_fold;
          end
        end
        st_fold: begin
          if (tick) begin
            state <= last_word ? st_finish : st_load;
          end
        end
        st_finish: begin
          if (tick) begin
            state <= st_load;
          end
        end
      endcase
    end
  end

  assign checking = (state != st_idle) && feature_on;

  // scan address walks every cell word then wraps for the next pass
  always_ff @(posedge sys_clk) begin
    if (restart) begin
      scan_addr <= '0;
    end else if (tick && state == st_fold) begin
      scan_addr <= last_word ? '0 : scan_addr + 1'b1;
    end
  end

  // running crc, reseeded after each compare
  always_ff @(posedge sys_clk) begin
    if (restart) begin
      crc <= CRC_INIT;
    end else if (tick && state == st_fold) begin
      crc <= crc_fold(crc, cell_word);
    end else if (tick && state == st_finish) begin
      crc <= CRC_INIT;
    end
  end

  // result and error only move at the compare step, so they hold through the next pass
  always_ff @(posedge sys_clk) begin
    if (restart) begin
      crc_compare_result <= RESULT_RESET;
      crc_error <= 1'b0;
    end else if (tick && state == st_finish) begin
      crc_compare_result <= next_result;
      crc_error <= |next_result;
    end
  end

  // one-cycle marker at the end of each pass
  always_ff @(posedge sys_clk) begin
    if (restart) begin
      pass_done <= 1'b0;
    end else begin
      pass_done <= tick && (state == st_finish);
    end
  end

endmodule : config_memory_error_check

/* File: testbench/cfg_check_checker.sv */
// port-level assertions for the configuration memory error checker
// assumes one clock domain; rst and a low config_restart_n both clear
`timescale 1ns/100ps
module cfg_check_checker #(
  parameter int WORDS = cfg_check_pkg::CELL_WORDS
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic config_restart_n,
  input wire cfg_check_pkg::cfg_load_t cfg_load,
  input wire logic rewrite_reference_instr,
  input wire logic jtag_shift,
  input wire logic jtag_tdi,
  input wire logic crc_error,
  input wire logic checking,
  input wire logic pass_done,
  input wire logic [31:0] crc_compare_result,
  input wire logic [31:0] reference_crc_value
);
  import cfg_check_pkg::*;
  logic seen;
  int gap;
  wire clr = rst || !config_restart_n;
  // cycles since the last pass end; the first pass is skipped as its start is not exact
  always_ff @(posedge sys_clk) begin
    if (clr) begin
      seen <= 1'b0;
      gap <= 0;
    end else begin
      seen <= seen | pass_done;
      gap <= pass_done ? 0 : gap + 1;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (clr);
  property p_err_from_result; crc_error == (crc_compare_result != 32'h0000_0000); endproperty
  a_err_from_result: assert property (p_err_from_result) else $error("error flag disagrees with result");
  // error and result move on the compare edge, the same edge that raises pass_done; a restart is not a pass end
  property p_err_at_end; $changed(crc_error) && !$past(clr) |-> pass_done; endproperty
  a_err_at_end: assert property (p_err_at_end) else $error("error flag moved inside a pass");
  property p_result_at_end; $changed(crc_compare_result) && !$past(clr) |-> pass_done; endproperty
  a_result_at_end: assert property (p_result_at_end) else $error("result moved inside a pass");
  property p_period; pass_done && seen |-> gap == ((2 * WORDS + 1) << cfg_load.div_exp) - 1; endproperty
  a_period: assert property (p_period) else $error("pass length wrong");
  property p_keeps_running; checking |=> checking; endproperty
  a_keeps_running: assert property (p_keeps_running) else $error("checking stopped");
  property p_auto_start; $rose(cfg_load.done) && cfg_load.enable |=> checking; endproperty
  a_auto_start: assert property (p_auto_start) else $error("checking did not start");
  property p_ref_load; $rose(cfg_load.done) |=> reference_crc_value == $past(cfg_load.reference); endproperty
  a_ref_load: assert property (p_ref_load) else $error("reference not loaded");
  property p_scan; rewrite_reference_instr && jtag_shift && $stable(cfg_load.done)
    |=> reference_crc_value == {$past(jtag_tdi), $past(reference_crc_value[31:1])}; endproperty
  a_scan: assert property (p_scan) else $error("reference scan shift wrong");
  property p_scan_hold; !(rewrite_reference_instr && jtag_shift) && $stable(cfg_load.done)
    |=> $stable(reference_crc_value); endproperty
  a_scan_hold: assert property (p_scan_hold) else $error("reference changed without scan");
endmodule : cfg_check_checker

bind config_memory_error_check cfg_check_checker #(.WORDS(WORDS)) checker_i (.sys_clk, .rst, .config_restart_n,
  .cfg_load, .rewrite_reference_instr, .jtag_shift, .jtag_tdi, .crc_error, .checking, .pass_done,
  .crc_compare_result, .reference_crc_value);

/* File: testbench/jtag_host_model.sv */
// test host that scans a new reference in and the old one out
// assumes the reference shifts right one bit per edge while instr and shift are high
`timescale 1ns/100ps
module jtag_host_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic go,
  input wire logic [31:0] value,
  input wire logic tdo,
  output logic instr,
  output logic shift,
  output logic tdi,
  output logic [31:0] saved,
  output logic busy
);
  logic [4:0] cnt;
  assign instr = busy;
  assign shift = busy;
  // one 32 bit frame; tdi flips after the frame so no stale bit lingers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      busy <= 1'b0;
      cnt <= 5'h00;
      tdi <= 1'b0;
    end else if (busy) begin
      saved <= {tdo, saved[31:1]};
      cnt <= cnt + 5'h01;
      if (cnt == 5'h1F) begin
        busy <= 1'b0;
        tdi <= ~tdi;
      end else begin
        tdi <= value[cnt + 5'h01];
      end
    end else if (go) begin
      busy <= 1'b1;
      cnt <= 5'h00;
      tdi <= value[0];
    end
  end
endmodule : jtag_host_model

/* File: testbench/config_memory_error_check_tb.sv */
// self-checking bench for the configuration memory error checker
// assumes an 8 word cell array; sys_clk at 40 MHz
`timescale 1ns/100ps
module config_memory_error_check_tb;
  import cfg_check_pkg::*;
  localparam int W = 8;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic config_restart_n = 1'b1;
  cfg_load_t cfg_load = '0;
  cell_write_t cell_wr = '0;
  logic go = 1'b0;
  logic [31:0] host_val = '0;
  logic instr, shift, tdi, tdo, crc_error, checking, pass_done, busy;
  logic [31:0] result, reference, saved, good;
  logic [31:0] cells [W];
  int errors = 0;
  int n_checks = 0;

  // 25 ns period
  always #12.5 sys_clk = ~sys_clk;

  config_memory_error_check #(.WORDS(W), .ADDR_W(3)) dut (.sys_clk, .rst, .config_restart_n, .cfg_load, .cell_wr,
    .rewrite_reference_instr(instr), .jtag_shift(shift), .jtag_tdi(tdi), .jtag_tdo(tdo), .crc_error, .checking,
    .pass_done, .crc_compare_result(result), .reference_crc_value(reference));
  jtag_host_model host (.sys_clk, .rst, .go, .value(host_val), .tdo, .instr, .shift, .tdi, .saved, .busy);

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish

  // msb first, no reflection, no final inversion
  function automatic logic [31:0] crc_of();
    logic [31:0] c;
    c = 32'hFFFF_FFFF;
    for (int i = 0; i < W; i++)
      for (int b = 31; b >= 0; b--)
        c = {c[30:0], 1'b0} ^ ((c[31] ^ cells[i][b]) ? CRC_POLY : 32'h0000_0000);
    return c;
  endfunction : crc_of

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick

  task automatic put_cell(input int a, input logic [31:0] d);
    cells[a] = d;
    @(posedge sys_clk);
    cell_wr <= '{1'b1, 10'(a), d};
    @(posedge sys_clk);
    cell_wr.we <= 1'b0;
  endtask : put_cell

  // two passes wait out the one already running when a change is made
  task automatic passes(input int n);
    repeat (n) begin
      tick(1);
      for (int t = 0; t < 9000 && pass_done !== 1'b1; t++) tick(1);
      check("pass_done", 1, pass_done);
    end
  endtask : passes

  task automatic host_write(input logic [31:0] v);
    @(posedge sys_clk);
    host_val <= v;
    go <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
    do tick(1); while (busy === 1'b1);
  endtask : host_write

  task automatic restart();
    @(posedge sys_clk);
    config_restart_n <= 1'b0;
    cfg_load.done <= 1'b0;
    @(posedge sys_clk);
    config_restart_n <= 1'b1;
    tick(1);
  endtask : restart

  initial begin
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    tick(1);
    check("checking", 0, checking);
    check("reference", 0, reference);
    $display("test reset finished");
    for (int i = 0; i < W; i++) put_cell(i, 32'hA5A5_5A5A ^ {8{4'(i)}});
    good = crc_of();
    @(posedge sys_clk);
    cfg_load <= '{1'b1, 1'b1, 4'h0, good};
    tick(1);
    check("checking", 1, checking);
    passes(2);
    check("result", 0, result);
    check("crc_error", 0, crc_error);
    $display("test clean pass finished");
    put_cell(3, cells[3] ^ 32'h0000_0100);
    passes(2);
    check("result", crc_of() ^ good, result);
    check("crc_error", 1, crc_error);
    passes(1);
    check("crc_error", 1, crc_error);
    put_cell(3, cells[3] ^ 32'h0000_0100);
    passes(2);
    check("crc_error", 0, crc_error);
    $display("test cell upset finished");
    host_write(~good);
    check("saved", good, saved);
    check("reference", ~good, reference);
    check("checking", 1, checking);
    passes(2);
    check("result", 32'hFFFF_FFFF, result);
    host_write(good);
    check("saved", ~good, saved);
    passes(2);
    check("crc_error", 0, crc_error);
    $display("test injection finished");
    restart();
    check("checking", 0, checking);
    @(posedge sys_clk);
    cfg_load <= '{1'b1, 1'b0, 4'h8, good};
    tick(50);
    check("checking", 0, checking);
    restart();
    @(posedge sys_clk);
    cfg_load <= '{1'b1, 1'b1, 4'h8, good};
    passes(2);
    check("result", 0, result);
    $display("test restart finished");
    tally_and_finish();
  end

  // whole run is near 9000 cycles
  initial begin
    repeat (40000) @(posedge sys_clk);
    errors++;
    tally_and_finish();
  end
endmodule : config_memory_error_check_tb
